// >>> supply_voltage_trip_detector_test.sv
// Self-checking bench for the supply voltage trip detector
`timescale 1ns/1ps
module supply_voltage_trip_detector_test
  import svtd_pkg::*;
;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata, o_rdata, rd_val;
  logic [3:0]        o_trip_level_select;
  logic              i_sys_clk, i_rst_n, i_wr, i_rd, i_at_or_above, i_at_or_below;
  logic              i_ref_stable, i_bandgap_stable, o_detector_power_enable;
  logic              o_trip_direction_select, o_use_external_input, o_irq, o_wake;
  int                error_cnt, n_tests;

  // Short settling count keeps the run brief
  svtd_detector #(.STAB_CNT(4)) svtd_detector_inst (.i_sys_clk, .i_rst_n, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_at_or_above, .i_at_or_below, .i_ref_stable,
    .i_bandgap_stable, .o_detector_power_enable, .o_trip_level_select,
    .o_trip_direction_select, .o_use_external_input, .o_irq, .o_wake);

  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus and check helpers
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  // Read data only stands in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 rd_val = o_rdata;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string nm);
    rd(a);
    chk(nm, exp, rd_val);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Poll the stable bit under a bounded count
  task automatic wait_stable();
    rd_val = '0;
    for (int k = 0; k < 60 && rd_val[REF_BIT] !== 1'b1; k++) rd(REG_CTRL);
    if (rd_val[REF_BIT] !== 1'b1) begin
      $display("[ERR] stable bit expected 1 seen %b", rd_val[REF_BIT]);
      error_cnt++;
      end_of_test();
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    error_cnt = 0;
    n_tests = 0;
    {i_rst_n, i_addr, i_wdata, i_wr, i_rd, i_at_or_above, i_at_or_below} = '0;
    {i_ref_stable, i_bandgap_stable} = 2'b00;
    repeat (4) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rdc(REG_CTRL, CTRL_RESET, "ctrl reset");
    chk("level reset", 8'h04, {4'h0, o_trip_level_select});
    wr(4'hA, 8'hFF);
    rdc(4'hA, ZERO_BYTE, "unmapped");
    // Status bits ignore writes; level F while off keeps the pin unrouted
    wr(REG_CTRL, 8'h6F);
    rdc(REG_CTRL, 8'h0F, "ctrl ro bits");
    chk("ext off", 8'h00, {7'h00, o_use_external_input});
    // Enable with the reference unstable while a fall trip is present
    @(posedge i_sys_clk) i_bandgap_stable <= 1'b1;
    wr(REG_CTRL, 8'h13);
    wr(REG_IRQC, 8'h80);
    wr(REG_IEN, 8'h04);
    wr(REG_FLAG, 8'h00);
    @(posedge i_sys_clk) i_at_or_below <= 1'b1;
    tick(20);
    rdc(REG_FLAG, ZERO_BYTE, "flag unstable");
    rdc(REG_CTRL, 8'h53, "not stable");
    @(posedge i_sys_clk) i_ref_stable <= 1'b1;
    wait_stable();
    tick(4);
    rdc(REG_FLAG, 8'h04, "fall trip");
    chk("irq", 8'h01, {7'h00, o_irq});
    // Flag outlives the trip until software clears it
    @(posedge i_sys_clk) i_at_or_below <= 1'b0;
    tick(10);
    chk("wake held", 8'h01, {7'h00, o_wake});
    rdc(REG_FLAG, 8'h04, "flag held");
    rdc(REG_FLAG, ZERO_BYTE, "flag cleared");
    chk("irq clear", 8'h00, {7'h00, o_irq});
    // Rise direction ignores a fall, then catches a rise
    wr(REG_CTRL, 8'h03);
    wr(REG_CTRL, 8'h93);
    @(posedge i_sys_clk) i_at_or_below <= 1'b1;
    // Reference already stable, so only the settling timer holds bit 5 low
    rdc(REG_CTRL, 8'hD3, "settling");
    wait_stable();
    tick(6);
    rdc(REG_FLAG, ZERO_BYTE, "wrong dir");
    chk("dir out", 8'h01, {7'h00, o_trip_direction_select});
    wr(REG_IRQC, 8'h00);
    @(posedge i_sys_clk) i_at_or_above <= 1'b1;
    tick(6);
    chk("irq masked", 8'h00, {7'h00, o_irq});
    chk("wake", 8'h01, {7'h00, o_wake});
    rdc(REG_FLAG, 8'h04, "rise trip");
    // Every level code, back to back
    for (int c = 0; c < 16; c++) begin
      wr(REG_CTRL, {4'h1, c[3:0]});
      tick(2);
      chk("level", {4'h0, c[3:0]}, {4'h0, o_trip_level_select});
      chk("ext", {7'h00, c[3:0] == 4'hF}, {7'h00, o_use_external_input});
    end
    wr(REG_CTRL, 8'h00);
    tick(2);
    chk("power off", 8'h00, {7'h00, o_detector_power_enable});
    rdc(REG_CTRL, 8'h40, "ctrl off");
    // Rise-trip flag is still up; a zero write must clear it, not only a read
    chk("wake set", 8'h01, {7'h00, o_wake});
    wr(REG_FLAG, 8'h00);
    rdc(REG_FLAG, ZERO_BYTE, "flag wr clear");
    end_of_test();
  end
endmodule // supply_voltage_trip_detector_test

// >>> svtd_detector.sv
// Supply voltage trip detector: control register, settling, event flag, interrupt
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RULE1: Detector powered only while control bit 4 is set.
// RULE2: Each enable rising edge starts a settling interval before comparisons count.
// RULE3: Control bit 5 is read-only, reads one once detector has settled.
// RULE4: Event flag cannot set while the stable bit is clear.
// RULE5: Bit 7 clear detects fall to or below trip; set detects rise.
// RULE6: Level field bits 3..0 select one of 16 levels, 0000 lowest.
// RULE7: Level code 1111 routes the external trip input to the comparator.
// RULE8: Reaching trip point in chosen direction sets the event flag.
// RULE9: Flag plus its enable (and global enable) requests an interrupt.
// RULE10: Software sets level, direction, enable, clears flag, then enables interrupts.
// RULE11: Software clears stale event flag at bit 2 during setup.
// RULE12: Software disables detector before changing direction or level.
// RULE13: Reset returns control register to reset value, detector off.
// RULE14: Detector keeps running in sleep; a trip sets flag and wakes.
// RULE15: Comparator and stable indications pass two flip-flops before use.
// RULE16: Event flag stays set until software clears it.
module svtd_detector
  import svtd_pkg::*;
#(
  parameter int STAB_CNT = STAB_CYCLES
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  input  wire logic              i_at_or_above,
  input  wire logic              i_at_or_below,
  input  wire logic              i_ref_stable,
  input  wire logic              i_bandgap_stable,
  output logic                   o_detector_power_enable,
  output logic      [3:0]        o_trip_level_select,
  output logic                   o_trip_direction_select,
  output logic                   o_use_external_input,
  output logic                   o_irq,
  output logic                   o_wake
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  svtd_ana_type   sync1;
  svtd_ana_type   ana;
  svtd_ana_type   raw_ana;
  svtd_state_type state;
  svtd_state_type next_state;
  svtd_ctrl_type  wr_view;
  svtd_ctrl_type  rd_view;
  logic             ctrl_dir;
  logic             ctrl_en;
  logic [3:0]       ctrl_level;
  logic             ext_sel;
  logic             event_flag;
  logic             event_ien;
  logic             global_ien;
  logic [CNT_W-1:0] settle_cnt;
  logic             irq_q;
  logic             wake_q;
  logic [7:0]       rdata_q;

  wire              wr_ctrl;
  wire              wr_flag;
  wire              wr_ien;
  wire              wr_irqc;
  wire              rd_flag;
  wire              cfg_change;
  wire              settle_done;
  wire              armed;
  wire              trip_now;
  wire              flag_clr;
  wire              next_dir;
  wire              next_en;
  wire [3:0]        next_level;
  wire              next_flag;
  wire              next_ien;
  wire              next_gie;
  wire [CNT_W-1:0]  next_cnt;
  wire [7:0]        rd_mux;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign wr_ctrl = i_wr & (i_addr == REG_CTRL);
  assign wr_flag = i_wr & (i_addr == REG_FLAG);
  assign wr_ien  = i_wr & (i_addr == REG_IEN);
  assign wr_irqc = i_wr & (i_addr == REG_IRQC);
  assign rd_flag = i_rd & (i_addr == REG_FLAG);
  assign wr_view = svtd_ctrl_type'(i_wdata);

  //////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the analog outputs
  assign raw_ana = '{at_or_above: i_at_or_above,
                     at_or_below: i_at_or_below,
                     ref_ok:      i_ref_stable,
                     bg_ok:       i_bandgap_stable};

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= '0;
      ana   <= '0;
    end else begin
      sync1 <= raw_ana;  // RULE15
      ana   <= sync1;    // RULE15
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register next values; stable bits are never written
  assign next_dir   = wr_ctrl ? wr_view.dir : ctrl_dir;      // RULE5
  assign next_en    = wr_ctrl ? wr_view.enable : ctrl_en;    // RULE1 RULE3
  assign next_level = wr_ctrl ? wr_view.level : ctrl_level;  // RULE6

  // A live retune restarts settling, guarding against a sloppy driver
  assign cfg_change = wr_ctrl & ctrl_en & wr_view.enable &
                      ((wr_view.dir != ctrl_dir) ||
                       (wr_view.level != ctrl_level));

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_dir   <= CTRL_RESET[DIR_BIT];    // RULE13
      ctrl_en    <= CTRL_RESET[EN_BIT];     // RULE13
      ctrl_level <= CTRL_RESET[3:0];        // RULE13
      ext_sel    <= 1'b0;
    end else begin
      ctrl_dir   <= next_dir;
      ctrl_en    <= next_en;
      ctrl_level <= next_level;
      ext_sel    <= next_en & (next_level == LEVEL_EXT);  // RULE7
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Settling sequencer: off, settle for the interval, then armed
  assign settle_done = (settle_cnt >= CNT_W'(STAB_CNT));
  // Gated by the enable so a disable stops trips and clears bit 5 at once
  assign armed       = (state == ST_ARMED) & ctrl_en;  // RULE1
  assign next_cnt    = ((state != ST_SETTLE) || cfg_change) ? '0 :
                       settle_done ? settle_cnt : settle_cnt + 1'b1;

  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (ctrl_en) begin
          next_state = ST_SETTLE;  // RULE2
        end
      end
      ST_SETTLE: begin
        if (!ctrl_en) begin
          next_state = ST_OFF;
        end else if (!cfg_change && settle_done && ana.ref_ok) begin
          next_state = ST_ARMED;   // RULE2 RULE3
        end
      end
      ST_ARMED: begin
        if (!ctrl_en) begin
          next_state = ST_OFF;
        end else if (cfg_change) begin
          next_state = ST_SETTLE;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state      <= ST_OFF;
      settle_cnt <= '0;
    end else begin
      state      <= next_state;
      settle_cnt <= next_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event flag: set wins over a read or write clear, held until cleared
  assign trip_now  = armed & svtd_is_trip(ctrl_dir, ana);  // RULE4 RULE5 RULE8
  assign flag_clr  = rd_flag | (wr_flag & ~i_wdata[EVT_BIT]);
  assign next_flag = trip_now | (event_flag & ~flag_clr);  // RULE16
  assign next_ien  = wr_ien  ? i_wdata[EVT_BIT] : event_ien;
  assign next_gie  = wr_irqc ? i_wdata[GIE_BIT] : global_ien;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      event_flag <= 1'b0;
      event_ien  <= 1'b0;
      global_ien <= 1'b0;
    end else begin
      event_flag <= next_flag;  // RULE8 RULE16
      event_ien  <= next_ien;
      global_ien <= next_gie;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt and wake; wake ignores the global enable as in sleep
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q  <= next_flag & next_ien & next_gie;  // RULE9
      wake_q <= next_flag & next_ien;             // RULE14
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path; unmapped offsets read zero
  assign rd_view = '{dir:        ctrl_dir,
                     bg_stable:  ana.bg_ok,
                     ref_stable: armed,   // RULE3
                     enable:     ctrl_en,
                     level:      ctrl_level};

  assign rd_mux = (i_addr == REG_CTRL) ? 8'(rd_view) :
                  (i_addr == REG_FLAG) ? 8'(event_flag) << EVT_BIT :
                  (i_addr == REG_IEN)  ? 8'(event_ien) << EVT_BIT :
                  (i_addr == REG_IRQC) ? 8'(global_ien) << GIE_BIT :
                  ZERO_BYTE;

  // Data stands only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= ZERO_BYTE;
    end else begin
      rdata_q <= i_rd ? rd_mux : ZERO_BYTE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flop
  assign o_rdata                 = rdata_q;
  assign o_detector_power_enable = ctrl_en;     // RULE1
  assign o_trip_level_select     = ctrl_level;  // RULE6
  assign o_trip_direction_select = ctrl_dir;
  assign o_use_external_input    = ext_sel;     // RULE7
  assign o_irq                   = irq_q;
  assign o_wake                  = wake_q;

endmodule // svtd_detector

// >>> svtd_detector_sva.sv
// Port assertions for the supply voltage trip detector
`timescale 1ns/1ps
module svtd_detector_sva
  import svtd_pkg::*;
#(
  parameter int STAB_CNT = STAB_CYCLES
) (
  input wire logic              i_sys_clk,
  input wire logic              i_rst_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic              i_at_or_above,
  input wire logic              i_at_or_below,
  input wire logic              i_ref_stable,
  input wire logic              i_bandgap_stable,
  input wire logic              o_detector_power_enable,
  input wire logic [3:0]        o_trip_level_select,
  input wire logic              o_trip_direction_select,
  input wire logic              o_use_external_input,
  input wire logic              o_irq,
  input wire logic              o_wake
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  //////////////////////////////////////////////////////////////////////////////
  // Control writes that switch the detector on and off
  sequence s_on;
    i_wr && i_addr == REG_CTRL && i_wdata[EN_BIT];
  endsequence
  sequence s_off;
    i_wr && i_addr == REG_CTRL && !i_wdata[EN_BIT];
  endsequence

  chk_power_on: assert property (s_on |-> ##[1:2] o_detector_power_enable)
    else $error("detector not powered after enable write");
  chk_power_off: assert property (s_off |-> ##[1:2] !o_detector_power_enable)
    else $error("detector still powered after disable write");
  chk_ext_route: assert property (o_use_external_input ==
    (o_detector_power_enable && o_trip_level_select == LEVEL_EXT))
    else $error("external input routing wrong");
  chk_irq_wake: assert property (o_irq |-> o_wake)
    else $error("interrupt without wake");
  chk_stable_off: assert property (
    $past(i_rd && i_addr == REG_CTRL && !o_detector_power_enable) |-> !o_rdata[REF_BIT])
    else $error("stable bit set while detector off");
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == ZERO_BYTE)
    else $error("read data not zero outside read cycle");
  chk_unmapped_zero: assert property ($past(i_rd && i_addr > REG_IRQC) |-> o_rdata == ZERO_BYTE)
    else $error("unmapped read not zero");
  // A trip needs two sync stages before it can raise the interrupt
  chk_irq_cause: assert property ($rose(o_irq) |-> $past(i_wr) || $past(i_wr, 2)
    || $past(i_at_or_above, 2) || $past(i_at_or_below, 2))
    else $error("interrupt rose without cause");
  chk_dir_write: assert property ($rose(o_trip_direction_select) |->
    $past(i_wr) || $past(i_wr, 2))
    else $error("direction changed without write");
endmodule // svtd_detector_sva

bind svtd_detector svtd_detector_sva #(.STAB_CNT(STAB_CNT)) svtd_detector_sva_inst (
  .i_sys_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_at_or_above,
  .i_at_or_below, .i_ref_stable, .i_bandgap_stable, .o_detector_power_enable,
  .o_trip_level_select, .o_trip_direction_select, .o_use_external_input, .o_irq, .o_wake);

// >>> svtd_pkg.sv
// Constants, types and helpers for the supply voltage trip detector
package svtd_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register bus geometry and map
  localparam int          ADDR_W     = 4;
  localparam int          DATA_W     = 8;
  localparam logic [3:0]  REG_CTRL   = 4'h0;  // voltage_detect_control
  localparam logic [3:0]  REG_FLAG   = 4'h1;  // peripheral_flag_reg_two
  localparam logic [3:0]  REG_IEN    = 4'h2;  // peripheral_enable_reg_two
  localparam logic [3:0]  REG_IRQC   = 4'h3;  // irq_control_reg

  //////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int          DIR_BIT    = 7;
  localparam int          BG_BIT     = 6;
  localparam int          REF_BIT    = 5;
  localparam int          EN_BIT     = 4;
  localparam int          EVT_BIT    = 2;     // Event flag and its enable
  localparam int          GIE_BIT    = 7;
  localparam logic [3:0]  LEVEL_EXT  = 4'hF;
  localparam logic [7:0]  CTRL_RESET = 8'h04;
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Timing: settling interval after enable, rounded up to whole cycles
  localparam int          CLK_PERIOD_PS = 25000;
  localparam int          STAB_TIME_NS  = 10000;
  localparam int          STAB_CYCLES   =
    (STAB_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          CNT_W         = 16;

  //////////////////////////////////////////////////////////////////////////////
  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       dir;
    logic       bg_stable;
    logic       ref_stable;
    logic       enable;
    logic [3:0] level;
  } svtd_ctrl_type;

  // Synchronised analog indications
  typedef struct packed {
    logic at_or_above;
    logic at_or_below;
    logic ref_ok;
    logic bg_ok;
  } svtd_ana_type;

  // Detector sequencing, Gray along off -> settle -> armed
  typedef enum logic [1:0] {
    ST_OFF    = 2'b00,
    ST_SETTLE = 2'b01,
    ST_ARMED  = 2'b11
  } svtd_state_type;

  // Trip test for the selected direction
  function automatic logic svtd_is_trip(input logic dir,
                                        input svtd_ana_type ana);
    svtd_is_trip = dir ? ana.at_or_above : ana.at_or_below;
  endfunction

endpackage
